// [travel_guard_defines.vh]
// Purpose: constants for the servo error-limit and negative travel guard
// Assumes: included by servo_error_limit_travel_guard.v
// Notes:   offsets are APB byte addresses, one 32-bit word each
`ifndef TRAVEL_GUARD_DEFINES_VH
`define TRAVEL_GUARD_DEFINES_VH
`define OFF_MOVE_LIM    12'h000
`define OFF_HOLD_LIM    12'h004
`define OFF_HOLD_DLY    12'h008
`define OFF_REM_SEL     12'h00C
`define OFF_REM_MAX     12'h010
`define OFF_EN_ISW      12'h014
`define OFF_LV_ISW      12'h018
`define OFF_EN_IS2      12'h01C
`define OFF_LV_IS2      12'h020
`define OFF_EN_XIO      12'h024
`define OFF_LV_XIO      12'h028
`define OFF_STATUS      12'h02C
`define OFF_MASK        12'h030
`define OFF_STATE       12'h034
`define RST_LIM         16'h0000
`define RST_HOLD_DLY    16'h0064
`define RST_WORD        16'h0000
`define REM_SEL_MIN     8'h0B
`define REM_SEL_MAX     8'hC7
`define REM_MAX_TOP     16'h7FFF
`define ST_MOVE_BIT     0
`define ST_HOLD_BIT     1
`define ST_NEG_BIT      2
`define ST_TORQ_BIT     3
`endif

// [servo_error_limit_travel_guard.v]
// Purpose: servo position error supervision, drag clamp and negative travel guard
// Assumes: positions are signed 32-bit, sampled on tick_i; APB slave, zero wait
// Notes:   status bits are sticky, cleared by a read of the status register
`timescale 1ns/1ns
`include "travel_guard_defines.vh"
module servo_error_limit_travel_guard (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        sys_rst_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // Servo loop
  input  wire        tick_i,
  input  wire        moving_i,
  input  wire [31:0] req_target_i,
  input  wire [31:0] actual_pos_i,
  input  wire [31:0] remote_pos_i,
  input  wire        remote_valid_i,
  input  wire [15:0] internal_status_word_i,
  input  wire [15:0] internal_status_word_two_i,
  input  wire [15:0] extended_io_word_i,
  // Results
  output reg  [31:0] target_o,
  output reg  [7:0]  remote_sel_o,
  output reg         holding_torque_o,
  output reg         neg_limit_o,
  output reg         irq_o
);
  reg  [15:0] move_lim_r;
  reg  [15:0] hold_lim_r;
  reg  [15:0] hold_dly_r;
  reg  [15:0] rem_max_r;
  reg  [15:0] en_isw_r, lv_isw_r, en_is2_r, lv_is2_r, en_xio_r, lv_xio_r;
  reg  [3:0]  status_r;
  reg  [3:0]  mask_r;
  reg  [15:0] dly_cnt_r;
  reg         rem_act_r;
  reg         move_err_r;
  reg         hold_err_r;

  // Absolute difference of two signed positions, saturated to 17 bits
  function [16:0] absdiff;
    input [31:0] a;
    input [31:0] b;
    reg   [32:0] d;
    begin
      d = {a[31], a} - {b[31], b};
      if (d[32])
        d = 33'h000000000 - d;
      absdiff = (d[32:16] != 17'h00000) ? 17'h1FFFF : d[16:0];
    end
  endfunction

  // Magnitude of a signed 16-bit limit
  function [16:0] limmag;
    input [15:0] l;
    begin
      limmag = l[15] ? (17'h00000 - {l[15], l}) : {1'b0, l};
    end
  endfunction

  // Enabled bit equal to its active level
  function hit;
    input [15:0] w;
    input [15:0] en;
    input [15:0] lv;
    begin
      hit = |(en & ~(w ^ lv));
    end
  endfunction

  wire        wr_en = psel_i & penable_i & pwrite_i;
  wire        rd_en = psel_i & penable_i & ~pwrite_i;
  wire [16:0] err_loc = absdiff(req_target_i, actual_pos_i);
  wire [16:0] err_rem = absdiff(req_target_i, remote_pos_i);
  wire [16:0] err_max = (rem_act_r && err_rem > err_loc) ? err_rem : err_loc;
  wire        rem_sel_ok = (remote_sel_o >= `REM_SEL_MIN) && (remote_sel_o <= `REM_SEL_MAX);
  wire [15:0] act_lim = moving_i ? move_lim_r : hold_lim_r;
  wire [16:0] act_mag = limmag(act_lim);
  wire        drag = act_lim[15];
  wire        neg_hit = hit(internal_status_word_i, en_isw_r, lv_isw_r) |
                        hit(internal_status_word_two_i, en_is2_r, lv_is2_r) |
                        hit(extended_io_word_i, en_xio_r, lv_xio_r);
  wire        ref_rem = rem_act_r && err_rem > err_loc;
  wire [31:0] ref_pos = ref_rem ? remote_pos_i : actual_pos_i;
  wire [31:0] hi_pos = ref_pos + {15'h0000, act_mag};
  wire [31:0] lo_pos = ref_pos - {15'h0000, act_mag};
  reg  [31:0] next_tgt;
  wire [3:0]  ev = {1'b0, neg_hit & ~neg_limit_o, hold_err_r, move_err_r};
  wire        rd_status = rd_en && paddr_i == `OFF_STATUS;

  // Negative guard then drag clamp
  always @* begin
    next_tgt = req_target_i;
    if (neg_hit && ($signed(req_target_i) < $signed(target_o)))
      next_tgt = target_o;
    if (drag) begin
      if ($signed(next_tgt) > $signed(hi_pos))
        next_tgt = hi_pos;
      else if ($signed(next_tgt) < $signed(lo_pos))
        next_tgt = lo_pos;
    end
  end

  // Servo tick processing
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      target_o         <= 32'h00000000;
      holding_torque_o <= 1'b0;
      neg_limit_o      <= 1'b0;
      dly_cnt_r        <= 16'h0000;
      rem_act_r        <= 1'b0;
      move_err_r       <= 1'b0;
      hold_err_r       <= 1'b0;
    end else begin
      move_err_r <= 1'b0;
      hold_err_r <= 1'b0;
      if (tick_i) begin
        target_o    <= next_tgt;
        neg_limit_o <= neg_hit;
        move_err_r  <= moving_i && err_max > limmag(move_lim_r);
        hold_err_r  <= !moving_i && err_max > limmag(hold_lim_r);
        if (!rem_sel_ok)
          rem_act_r <= 1'b0;
        else if (!rem_act_r && remote_valid_i &&
                 absdiff(actual_pos_i, remote_pos_i) <= {1'b0, rem_max_r})
          rem_act_r <= 1'b1;
        if (moving_i) begin
          dly_cnt_r        <= 16'h0000;
          holding_torque_o <= 1'b0;
        end else if (dly_cnt_r >= hold_dly_r) begin
          holding_torque_o <= 1'b1;
        end else begin
          dly_cnt_r <= dly_cnt_r + 16'h0001;
        end
      end
    end
  end

  // Registers and APB
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      move_lim_r   <= `RST_LIM;
      hold_lim_r   <= `RST_LIM;
      hold_dly_r   <= `RST_HOLD_DLY;
      remote_sel_o <= 8'h00;
      rem_max_r    <= `RST_WORD;
      en_isw_r     <= `RST_WORD;
      lv_isw_r     <= `RST_WORD;
      en_is2_r     <= `RST_WORD;
      lv_is2_r     <= `RST_WORD;
      en_xio_r     <= `RST_WORD;
      lv_xio_r     <= `RST_WORD;
      mask_r       <= 4'h0;
      status_r     <= 4'h0;
      prdata_o     <= 32'h00000000;
      pready_o     <= 1'b0;
      pslverr_o    <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      // Set wins over the clearing read
      status_r  <= (rd_status && pready_o ? 4'h0 : status_r) | ev;
      irq_o     <= |((status_r | ev) & mask_r);
      if (psel_i && penable_i && pready_o) begin
        if (wr_en) begin
          case (paddr_i)
            `OFF_MOVE_LIM: move_lim_r <= pwdata_i[15:0];
            `OFF_HOLD_LIM: hold_lim_r <= pwdata_i[15:0];
            `OFF_HOLD_DLY: hold_dly_r <= pwdata_i[15:0];
            `OFF_REM_SEL:  remote_sel_o <= pwdata_i[7:0];
            `OFF_REM_MAX:  rem_max_r <= pwdata_i[15:0] & `REM_MAX_TOP;
            `OFF_EN_ISW:   en_isw_r <= pwdata_i[15:0];
            `OFF_LV_ISW:   lv_isw_r <= pwdata_i[15:0];
            `OFF_EN_IS2:   en_is2_r <= pwdata_i[15:0];
            `OFF_LV_IS2:   lv_is2_r <= pwdata_i[15:0];
            `OFF_EN_XIO:   en_xio_r <= pwdata_i[15:0];
            `OFF_LV_XIO:   lv_xio_r <= pwdata_i[15:0];
            `OFF_MASK:     mask_r <= pwdata_i[3:0];
            default:       ;
          endcase
        end
      end else if (psel_i && !penable_i) begin
        prdata_o <= 32'h00000000;
        case (paddr_i)
          `OFF_MOVE_LIM: prdata_o <= {16'h0000, move_lim_r};
          `OFF_HOLD_LIM: prdata_o <= {16'h0000, hold_lim_r};
          `OFF_HOLD_DLY: prdata_o <= {16'h0000, hold_dly_r};
          `OFF_REM_SEL:  prdata_o <= {24'h000000, remote_sel_o};
          `OFF_REM_MAX:  prdata_o <= {16'h0000, rem_max_r};
          `OFF_EN_ISW:   prdata_o <= {16'h0000, en_isw_r};
          `OFF_LV_ISW:   prdata_o <= {16'h0000, lv_isw_r};
          `OFF_EN_IS2:   prdata_o <= {16'h0000, en_is2_r};
          `OFF_LV_IS2:   prdata_o <= {16'h0000, lv_is2_r};
          `OFF_EN_XIO:   prdata_o <= {16'h0000, en_xio_r};
          `OFF_LV_XIO:   prdata_o <= {16'h0000, lv_xio_r};
          `OFF_STATUS:   prdata_o <= {28'h0000000, status_r | ev};
          `OFF_MASK:     prdata_o <= {28'h0000000, mask_r};
          `OFF_STATE:    prdata_o <= {28'h0000000, holding_torque_o, neg_limit_o,
                                      rem_act_r, drag};
          default:       prdata_o <= 32'h00000000;
        endcase
        // Flag decided at setup so it stands beside pready
        if (pwrite_i && (paddr_i > `OFF_STATE || paddr_i[1:0] != 2'b00))
          pslverr_o <= 1'b1;
      end
    end
  end
endmodule // servo_error_limit_travel_guard

// [travel_guard_asserts.sv]
// Purpose: port checks for the servo travel guard
// Assumes: one clock, sync reset, ready one cycle after setup
// Notes:   bound to the top module
`timescale 1ns/1ns
module travel_guard_asserts (
  // Watched ports
  input wire        core_clk_i,
  input wire        sys_rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        tick_i,
  input wire        moving_i,
  input wire [31:0] target_o,
  input wire        holding_torque_o,
  input wire        neg_limit_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  property p_rdy; s_setup |=> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_rdy_one; pready_o |=> !pready_o; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
  property p_slv;
    (s_setup and (pwrite_i && paddr_i > 12'h034)) |=> pslverr_o && pready_o;
  endproperty
  a_slv: assert property (p_slv) else $error("no error on unmapped write");
  property p_rd_ok; (s_setup and !pwrite_i) |=> !pslverr_o; endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("read flagged");
  property p_tick; !tick_i |=> $stable(target_o) && $stable(neg_limit_o); endproperty
  a_tick: assert property (p_tick) else $error("update off tick");
  property p_neg; $signed(target_o) < $signed($past(target_o)) |-> !neg_limit_o; endproperty
  a_neg: assert property (p_neg) else $error("decrease while guarded");
  property p_hold_mv; tick_i && moving_i |=> !holding_torque_o; endproperty
  a_hold_mv: assert property (p_hold_mv) else $error("holding while moving");
  property p_hold_up; $rose(holding_torque_o) |-> !$past(moving_i); endproperty
  a_hold_up: assert property (p_hold_up) else $error("holding too early");
endmodule // travel_guard_asserts
bind servo_error_limit_travel_guard travel_guard_asserts u_chk (.*);

// [apb_host.sv]
// Purpose: host model issuing configuration words
// Assumes: slave may stretch the access phase
// Notes:   waits for ready without limit, bench watchdog judges
`timescale 1ns/1ns
module apb_host (
  // Bus
  input  wire        core_clk_i,
  input  wire        pready_i,
  input  wire        pslverr_i,
  input  wire [31:0] prdata_i,
  output reg         psel_o    = 1'b0,
  output reg         penable_o = 1'b0,
  output reg         pwrite_o  = 1'b0,
  output reg  [11:0] paddr_o   = 12'h000,
  output reg  [31:0] pwdata_o  = 32'h0000_0000
);
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge core_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    do @(posedge core_clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule // apb_host

// [servo_error_limit_travel_guard_tb.sv]
// Purpose: self-checking bench for the servo travel guard
// Assumes: host model speaks the register bus
// Notes:   one task per scenario
`timescale 1ns/1ns
module servo_error_limit_travel_guard_tb;
  logic        clk = 0, rst = 1, tick = 0, mov = 0, rv = 0, e;
  logic        psel, pen, pwr, rdy, err, ht, nl, irq;
  logic [11:0] pa;
  logic [31:0] pwd, prd, tgt, q, rq = 0, act = 0, rp = 0;
  logic [15:0] w1 = 0, w2 = 0, w3 = 16'hFFFF;
  logic [7:0]  rs;
  int          n_fail = 0, checks = 0;
  apb_host u_host (.core_clk_i(clk), .pready_i(rdy), .pslverr_i(err), .prdata_i(prd),
    .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(pa), .pwdata_o(pwd));
  servo_error_limit_travel_guard i_dut (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(err), .tick_i(tick), .moving_i(mov), .req_target_i(rq),
    .actual_pos_i(act), .remote_pos_i(rp), .remote_valid_i(rv), .internal_status_word_i(w1),
    .internal_status_word_two_i(w2), .extended_io_word_i(w3), .target_o(tgt),
    .remote_sel_o(rs), .holding_torque_o(ht), .neg_limit_o(nl), .irq_o(irq));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, x, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    u_host.xfer(1'b0, a, 32'h0, q, e);
    chk("read", q, x);
  endtask
  task tk(input int n);
    repeat (n) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
    end
    @(posedge clk);
  endtask
  task conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task t_reset;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h64);
    wr(12'h040, 32'h0);
    chk("slverr", e, 32'h1);
  endtask
  task t_err;
    wr(12'h000, 32'hA);
    wr(12'h004, 32'h5);
    mov <= 1'b1;
    rq <= 32'hFFFF_FFF1;
    tk(1);
    rq <= 32'h0;
    repeat (2) @(posedge clk);
    chk("irq", irq, 32'h0);
    wr(12'h030, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq", irq, 32'h1);
    wr(12'h030, 32'h0);
    rd(12'h02C, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", irq, 32'h0);
    wr(12'h008, 32'h0);
    mov <= 1'b0;
    rq <= 32'h8;
    tk(2);
    rq <= 32'h0;
    chk("ht", ht, 32'h1);
    rd(12'h02C, 32'h2);
  endtask
  task t_delay;
    wr(12'h008, 32'h3);
    mov <= 1'b1;
    tk(1);
    mov <= 1'b0;
    tk(2);
    chk("ht", ht, 32'h0);
    tk(1);
    chk("ht", ht, 32'h0);
    tk(1);
    chk("ht", ht, 32'h1);
  endtask
  task t_drag;
    wr(12'h000, 32'hFFFB);
    mov <= 1'b1;
    act <= 32'h64;
    rq <= 32'hC8;
    tk(1);
    chk("drag", tgt, 32'h69);
    rq <= 32'h0;
    tk(1);
    chk("drag", tgt, 32'h5F);
    rd(12'h02C, 32'h1);
    rd(12'h034, 32'h1);
  endtask
  task t_guard;
    wr(12'h000, 32'h7FFF);
    wr(12'h024, 32'h2000);
    wr(12'h028, 32'h0);
    act <= 32'h0;
    rq <= 32'h32;
    tk(1);
    chk("tgt", tgt, 32'h32);
    w3 <= 16'hDFFF;
    rq <= 32'h14;
    tk(1);
    chk("tgt", tgt, 32'h32);
    chk("nl", nl, 32'h1);
    rq <= 32'h50;
    tk(1);
    chk("tgt", tgt, 32'h50);
    w3 <= 16'hFFFF;
    rq <= 32'h1E;
    tk(1);
    chk("tgt", tgt, 32'h1E);
    rd(12'h02C, 32'h4);
  endtask
  task t_remote;
    rp <= 32'h64;
    rv <= 1'b1;
    rq <= 32'h0;
    wr(12'h000, 32'h32);
    wr(12'h010, 32'hC8);
    wr(12'h00C, 32'hBE);
    tk(1);
    chk("sel", rs, 32'hBE);
    rd(12'h034, 32'h2);
    tk(1);
    rd(12'h02C, 32'h1);
    wr(12'h00C, 32'h0);
    tk(1);
    rd(12'h034, 32'h0);
    wr(12'h010, 32'h32);
    wr(12'h00C, 32'hBE);
    tk(1);
    rd(12'h034, 32'h0);
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    #100000;
    n_fail++;
    conclude;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_err;
    t_delay;
    t_drag;
    t_guard;
    t_remote;
    conclude;
  end
endmodule // servo_error_limit_travel_guard_tb
